/* File: logic/fbcl_top.sv */
// Fuse-held brown-out detector configuration and reset-time calibration loader
//
// Implementation choices: the register addresses and the Wishbone slave port.
module fbcl_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_POR_N,
    input  wire logic        I_RST_CAUSE_BOD,
    input  wire logic        I_CHIP_ERASE,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [31:0] I_WB_DAT,
    input  wire logic [3:0]  I_WB_SEL,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    output logic             O_WB_ERR,
    output logic             O_CPU_RST_N,
    output logic             O_BOD_ENABLE,
    output logic             O_BOD_RESET_EN,
    output logic             O_BOD_HYST,
    output logic      [5:0]  O_BOD_LEVEL,
    output logic      [15:0] O_REGION_LOCK,
    output logic             O_CAL_DONE
);

    // Synchronised reset cause and chip erase request
    logic                        bod_cause;
    logic                        erase_lvl;
    logic                        erase_prev_q;
    logic                        erase_pulse;

    // Fuse storage and retained detector control
    fbcl_pkg::fbcl_fuse_word_type fuse_q;
    fbcl_pkg::fbcl_det_ctrl_type  det_q;
    fbcl_pkg::fbcl_fuse_word_type fuse_snap_q;
    logic                        cal_done_q;

    // Sequencer
    fbcl_pkg::fbcl_seq_type      seq_q;
    logic [3:0]                  read_cnt_q;
    logic [2:0]                  settle_cnt_q;
    logic                        cause_q;

    // Bus decode
    logic                        req;
    logic                        hit_fuse;
    logic                        hit_ctrl;
    logic                        hit_status;
    logic                        hit_any;
    logic                        sw_wr_ctrl;
    logic [31:0]                 ctrl_word;
    logic [31:0]                 status_word;
    logic [31:0]                 rd_data;
    logic                        do_load;
    logic                        in_run;

    // Reset cause and erase request come from outside the clock domain
    fbcl_sync u_sync_cause (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_async (I_RST_CAUSE_BOD),
        .o_level (bod_cause)
    );

    fbcl_sync u_sync_erase (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_async (I_CHIP_ERASE),
        .o_level (erase_lvl)
    );

    // Rising edge of the filtered erase request
    // Both stages reset low, matching the idle level of the request pin
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            erase_prev_q <= 1'h0;
        end else begin
            erase_prev_q <= erase_lvl;
        end
    end

    assign erase_pulse = erase_lvl & ~erase_prev_q;

    // Non-volatile fuse word; only power-on returns it to the shipped value
    // It stands for the fuse cells themselves, so system resets leave it alone
    always_ff @(posedge I_CLK or negedge I_POR_N) begin
        if (!I_POR_N) begin
            fuse_q <= fbcl_pkg::FUSE_FACTORY;
        end else if (erase_pulse) begin
            fuse_q <= fbcl_pkg::FUSE_ERASED;
        end
    end

    // Settle counter: lets the cause synchroniser agree after reset release
    // The cause input must hold steady from before release until the capture edge
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            settle_cnt_q <= fbcl_pkg::CAUSE_SETTLE_CNT;
        end else if (seq_q == fbcl_pkg::SEQ_SETTLE && settle_cnt_q != 3'h0) begin
            settle_cnt_q <= settle_cnt_q - 3'h1;
        end
    end

    // Reset cause caught once, after release
    // Caught once so a later change of the cause pin cannot alter the decision
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cause_q <= 1'h0;
        end else if (seq_q == fbcl_pkg::SEQ_SETTLE && settle_cnt_q == 3'h0) begin
            cause_q <= bod_cause;
        end
    end

    // Fuse read delay counter
    // The fuse array needs this long before its outputs are valid
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            read_cnt_q <= fbcl_pkg::FUSE_READ_CNT;
        end else if (seq_q == fbcl_pkg::SEQ_READ) begin
            read_cnt_q <= read_cnt_q - 4'h1;
        end else begin
            read_cnt_q <= fbcl_pkg::FUSE_READ_CNT;
        end
    end

    // Loader sequence: settle, decide, read fuses, load, run
    // A skipped load goes from decide straight to run
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            seq_q <= fbcl_pkg::SEQ_SETTLE;
        end else begin
            unique case (seq_q)
                fbcl_pkg::SEQ_SETTLE: begin
                    if (settle_cnt_q == 3'h0) begin
                        seq_q <= fbcl_pkg::SEQ_DECIDE;
                    end
                end
                fbcl_pkg::SEQ_DECIDE: begin
                    if (cause_q && cal_done_q) begin
                        seq_q <= fbcl_pkg::SEQ_RUN;
                    end else begin
                        seq_q <= fbcl_pkg::SEQ_READ;
                    end
                end
                fbcl_pkg::SEQ_READ: begin
                    if (read_cnt_q == 4'h0) begin
                        seq_q <= fbcl_pkg::SEQ_LOAD;
                    end
                end
                fbcl_pkg::SEQ_LOAD: begin
                    seq_q <= fbcl_pkg::SEQ_RUN;
                end
                fbcl_pkg::SEQ_RUN: begin
                    seq_q <= fbcl_pkg::SEQ_RUN;
                end
            endcase
        end
    end

    // Fuse contents sampled at the end of the read delay
    // The snapshot keeps the load source steady even if an erase lands mid-load
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fuse_snap_q <= '0;
        end else if (seq_q == fbcl_pkg::SEQ_READ && read_cnt_q == 4'h0) begin
            fuse_snap_q <= fuse_q;
        end
    end

    // Load strobe and hand-over state, both straight from the sequencer
    assign do_load = (seq_q == fbcl_pkg::SEQ_LOAD);
    assign in_run  = (seq_q == fbcl_pkg::SEQ_RUN);

    // Bus decode; writes only once the loader has handed over
    // A write that lands while busy is acked and dropped, so a load is never torn
    assign req        = I_WB_CYC & I_WB_STB & ~O_WB_ACK & ~O_WB_ERR;
    assign hit_fuse   = (I_WB_ADR == fbcl_pkg::OFS_FUSE_LOW);
    assign hit_ctrl   = (I_WB_ADR == fbcl_pkg::OFS_DET_CTRL);
    assign hit_status = (I_WB_ADR == fbcl_pkg::OFS_STATUS);
    assign hit_any    = hit_fuse | hit_ctrl | hit_status;
    assign sw_wr_ctrl = req & I_WB_WE & hit_ctrl & in_run;

    // Retained detector control: survives a brown-out reset, load or software write updates it
    // Held on the power-on reset only, so a brown-out reset can skip the reload
    always_ff @(posedge I_CLK or negedge I_POR_N) begin
        if (!I_POR_N) begin
            det_q.ctrl  <= fbcl_pkg::CTRL_RESET;
            det_q.hyst  <= fbcl_pkg::HYST_RESET;
            det_q.level <= fbcl_pkg::LEVEL_RESET;
        end else if (do_load) begin
            det_q.ctrl  <= fuse_snap_q.det_enable;
            det_q.hyst  <= fuse_snap_q.det_hyst;
            det_q.level <= fuse_snap_q.det_level;
        end else if (sw_wr_ctrl) begin
            if (I_WB_SEL[0]) begin
                det_q.ctrl <= I_WB_DAT[fbcl_pkg::CTRL_POS +: 2];
                det_q.hyst <= I_WB_DAT[fbcl_pkg::HYST_POS];
            end
            if (I_WB_SEL[1]) begin
                det_q.level <= I_WB_DAT[fbcl_pkg::LEVEL_POS +: 6];
            end
        end
    end

    // Calibration-done flag: cleared by any non brown-out reset, set by a load
    // Clear and set never meet: the clear falls in decide, the set in load
    always_ff @(posedge I_CLK or negedge I_POR_N) begin
        if (!I_POR_N) begin
            cal_done_q <= fbcl_pkg::CAL_DONE_RESET;
        end else if (do_load) begin
            cal_done_q <= 1'h1;
        end else if (seq_q == fbcl_pkg::SEQ_DECIDE && !cause_q) begin
            cal_done_q <= 1'h0;
        end
    end

    // Processor held in reset until the loader reaches run
    // Registered so the release never glitches while the state bits change
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CPU_RST_N <= 1'h0;
        end else begin
            O_CPU_RST_N <= in_run;
        end
    end

    // Detector enable and reset enable decoded from the control field
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_BOD_ENABLE   <= 1'h0;
            O_BOD_RESET_EN <= 1'h0;
        end else begin
            unique case (det_q.ctrl)
                fbcl_pkg::DET_ON_RESET: begin
                    O_BOD_ENABLE   <= 1'h1;
                    O_BOD_RESET_EN <= 1'h1;
                end
                fbcl_pkg::DET_ON_NO_RESET: begin
                    O_BOD_ENABLE   <= 1'h1;
                    O_BOD_RESET_EN <= 1'h0;
                end
                fbcl_pkg::DET_OFF_LOW, fbcl_pkg::DET_OFF_HIGH: begin
                    O_BOD_ENABLE   <= 1'h0;
                    O_BOD_RESET_EN <= 1'h0;
                end
            endcase
        end
    end

    // Hysteresis and threshold pass straight through; level zero never trips
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_BOD_HYST  <= 1'h0;
            O_BOD_LEVEL <= fbcl_pkg::LEVEL_LOWEST;
        end else begin
            O_BOD_HYST  <= det_q.hyst;
            O_BOD_LEVEL <= det_q.level;
        end
    end

    // Region locks: a fuse at one leaves its region open
    // Locks follow the live fuse word, so an erase reopens regions at once
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_REGION_LOCK <= ~fbcl_pkg::LOCK_NONE;
        end else begin
            O_REGION_LOCK <= ~fuse_q.region_lock;
        end
    end

    // Flag mirror on a pin
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CAL_DONE <= 1'h0;
        end else begin
            O_CAL_DONE <= cal_done_q;
        end
    end

    // Detector control register image
    always_comb begin
        ctrl_word                           = 32'h0;
        ctrl_word[fbcl_pkg::CTRL_POS +: 2]  = det_q.ctrl;
        ctrl_word[fbcl_pkg::HYST_POS]       = det_q.hyst;
        ctrl_word[fbcl_pkg::LEVEL_POS +: 6] = det_q.level;
        ctrl_word[fbcl_pkg::CAL_DONE_POS]   = cal_done_q;
    end

    // Status register image: busy until the loader hands over
    always_comb begin
        status_word                          = 32'h0;
        status_word[fbcl_pkg::BUSY_POS]      = ~in_run;
        status_word[fbcl_pkg::BOD_CAUSE_POS] = cause_q;
    end

    // Read data mux
    always_comb begin
        rd_data = 32'h0;
        if (hit_fuse) begin
            rd_data = fuse_q;
        end else if (hit_ctrl) begin
            rd_data = ctrl_word;
        end else if (hit_status) begin
            rd_data = status_word;
        end
    end

    // Bus answer: ack for mapped offsets, err for others, one cycle each
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WB_ACK <= 1'h0;
            O_WB_ERR <= 1'h0;
        end else begin
            O_WB_ACK <= req & hit_any;
            O_WB_ERR <= req & ~hit_any;
        end
    end

    // Read data captured on a taken read and held until the next one
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WB_DAT <= 32'h0;
        end else if (req & hit_any & ~I_WB_WE) begin
            O_WB_DAT <= rd_data;
        end
    end

endmodule : fbcl_top

/* File: logic/fbcl_pkg.sv */
// Shared constants, field layouts and types of the fuse-held detector configuration loader
package fbcl_pkg;

    // Clock rate and timing
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned FUSE_READ_NS      = 100;
    localparam int unsigned FUSE_READ_CYCLES  = (FUSE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  FUSE_READ_CNT     = 4'(FUSE_READ_CYCLES - 1);
    localparam logic [2:0]  CAUSE_SETTLE_CNT  = 3'h4;

    // Fuse word contents
    localparam logic [31:0] FUSE_FACTORY      = 32'he07fffff;
    localparam logic [31:0] FUSE_ERASED       = 32'h0fffffff;

    // Detector enable field encodings, lowest threshold level and no-lock fuse mask
    localparam logic [1:0]  DET_OFF_LOW       = 2'h0;
    localparam logic [1:0]  DET_ON_RESET      = 2'h1;
    localparam logic [1:0]  DET_ON_NO_RESET   = 2'h2;
    localparam logic [1:0]  DET_OFF_HIGH      = 2'h3;
    localparam logic [5:0]  LEVEL_LOWEST      = 6'h00;
    localparam logic [15:0] LOCK_NONE         = 16'hffff;

    // Register byte offsets
    localparam logic [7:0]  OFS_FUSE_LOW      = 8'h00;
    localparam logic [7:0]  OFS_DET_CTRL      = 8'h04;
    localparam logic [7:0]  OFS_STATUS        = 8'h08;

    // Detector control register field positions
    localparam int unsigned CTRL_POS          = 0;
    localparam int unsigned HYST_POS          = 2;
    localparam int unsigned LEVEL_POS         = 8;
    localparam int unsigned CAL_DONE_POS      = 31;

    // Status register field positions
    localparam int unsigned BUSY_POS          = 0;
    localparam int unsigned BOD_CAUSE_POS     = 1;

    // Reset values of retained and control state
    localparam logic [1:0]  CTRL_RESET        = DET_OFF_HIGH;
    localparam logic        HYST_RESET        = 1'h0;
    localparam logic [5:0]  LEVEL_RESET       = LEVEL_LOWEST;
    localparam logic        CAL_DONE_RESET    = 1'h0;

    // Layout of the low general-purpose fuse word
    typedef struct packed {
        logic [1:0]  det_enable;
        logic        det_hyst;
        logic [5:0]  det_level;
        logic        user_page_protect;
        logic [1:0]  secure;
        logic [2:0]  boot_area_protect;
        logic        external_fetch_lock;
        logic [15:0] region_lock;
    } fbcl_fuse_word_type;

    // Detector control fields
    typedef struct packed {
        logic [1:0] ctrl;
        logic       hyst;
        logic [5:0] level;
    } fbcl_det_ctrl_type;

    // Loader sequence states
    typedef enum logic [2:0] {
        SEQ_SETTLE,
        SEQ_DECIDE,
        SEQ_READ,
        SEQ_LOAD,
        SEQ_RUN
    } fbcl_seq_type;

endpackage : fbcl_pkg

/* File: logic/fbcl_sync.sv */
// Three-stage synchroniser whose output follows once the last two stages agree
module fbcl_sync (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_level
);

    logic meta_q;
    logic s2_q;
    logic s3_q;

    // Shift chain; only s2 reads the first stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'h0;
            s2_q   <= 1'h0;
            s3_q   <= 1'h0;
        end else begin
            meta_q <= i_async;
            s2_q   <= meta_q;
            s3_q   <= s2_q;
        end
    end

    // Output moves only when the two later stages agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_level <= 1'h0;
        end else if (s2_q == s3_q) begin
            o_level <= s3_q;
        end
    end

endmodule : fbcl_sync

/* File: tb/fbcl_chk_sva.sv */
// Concurrent checks on the loader's bus answers, reset release and detector outputs
module fbcl_chk (
    input wire logic        I_CLK,
    input wire logic        I_RST_N,
    input wire logic        I_WB_CYC,
    input wire logic        I_WB_STB,
    input wire logic        I_WB_WE,
    input wire logic [7:0]  I_WB_ADR,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [3:0]  I_WB_SEL,
    input wire logic        O_WB_ACK,
    input wire logic        O_WB_ERR,
    input wire logic        O_CPU_RST_N,
    input wire logic        O_BOD_ENABLE,
    input wire logic        O_BOD_RESET_EN,
    input wire logic        O_BOD_HYST,
    input wire logic [5:0]  O_BOD_LEVEL,
    input wire logic        O_CAL_DONE
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    logic       req;
    logic       map;
    logic [2:0] wd_q;

    // A request not yet answered, and whether it hits a mapped offset
    assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
    assign map = I_WB_ADR inside {8'h00, 8'h04, 8'h08};

    // Write data low bits one cycle back, for the control write check
    always_ff @(posedge I_CLK) begin
        wd_q <= I_WB_DAT[2:0];
    end

    a_mapped_ack: assert property (req && map |=> O_WB_ACK && !O_WB_ERR)
        else $error("mapped access not acked");
    a_unmapped_err: assert property (req && !map |=> O_WB_ERR && !O_WB_ACK)
        else $error("unmapped access not refused");
    a_answer_pulse: assert property ((O_WB_ACK || O_WB_ERR) |=> !O_WB_ACK && !O_WB_ERR)
        else $error("bus answer longer than one cycle");
    a_enable_decode: assert property (O_BOD_RESET_EN |-> O_BOD_ENABLE)
        else $error("reset enabled with detector off");
    a_release_window: assert property ($rose(I_RST_N) |-> !O_CPU_RST_N [*5] ##[1:40] O_CPU_RST_N)
        else $error("processor release out of window");
    a_cal_first: assert property ($rose(O_CPU_RST_N) |-> ##[0:1] O_CAL_DONE)
        else $error("processor released before calibration done");
    a_fields_hold: assert property (O_CPU_RST_N && $past(O_CPU_RST_N, 2) && !O_WB_ACK && !$past(O_WB_ACK)
        |=> $stable(O_BOD_LEVEL) && $stable(O_BOD_HYST))
        else $error("detector fields changed while running");
    a_ctrl_write: assert property (O_WB_ACK && I_WB_WE && I_WB_ADR == 8'h04 && I_WB_SEL[0] && O_CPU_RST_N
        |=> O_BOD_HYST == wd_q[2] && O_BOD_ENABLE == ^wd_q[1:0])
        else $error("control write not applied");

    c_refused: cover property (req && !map);
    c_release: cover property ($rose(O_CPU_RST_N));
    c_reset_en: cover property (O_BOD_RESET_EN);
endmodule : fbcl_chk

bind fbcl_top fbcl_chk i_fbcl_chk (.I_CLK, .I_RST_N, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR,
    .I_WB_DAT, .I_WB_SEL, .O_WB_ACK, .O_WB_ERR, .O_CPU_RST_N, .O_BOD_ENABLE, .O_BOD_RESET_EN,
    .O_BOD_HYST, .O_BOD_LEVEL, .O_CAL_DONE);

/* File: tb/fbcl_rst_src.sv */
// Reset source model standing in for the power supervisor and brown-out detector
module fbcl_rst_src (
    input  wire logic i_clk,
    output logic      o_por_n,
    output logic      o_rst_n,
    output logic      o_cause_bod
);
    timeunit 1ns;
    timeprecision 1ps;

    // All resets asserted at power-up
    initial begin
        o_por_n = 1'b0;
        o_rst_n = 1'b0;
        o_cause_bod = 1'b0;
    end

    // Reset pulse; kind bit 0 marks a brown-out cause, bit 1 a power-on reset
    // Cause stays put until the next pulse, well past the capture window
    task automatic pulse(input logic [1:0] kind, input int len);
        o_cause_bod <= kind[0];
        o_por_n <= !kind[1];
        o_rst_n <= 1'b0;
        repeat (len) @(posedge i_clk);
        o_por_n <= 1'b1;
        o_rst_n <= 1'b1;
    endtask : pulse
endmodule : fbcl_rst_src

/* File: tb/tb.sv */
// Self-checking bench for the fuse-held detector configuration loader
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        por_n;
    logic        rst_n;
    logic        cause;
    logic        erase = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        err;
    logic        cpu_n;
    logic        en;
    logic        ren;
    logic        hyst;
    logic        done;
    logic [5:0]  lvl;
    logic [15:0] lock;
    logic [31:0] q;
    logic        e;
    int          bad_count = 0;
    int          check_count = 0;

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    fbcl_rst_src i_fbcl_rst_src (.i_clk(clk), .o_por_n(por_n), .o_rst_n(rst_n), .o_cause_bod(cause));

    fbcl_top i_fbcl_top (.I_CLK(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_RST_CAUSE_BOD(cause),
        .I_CHIP_ERASE(erase), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_WB_ERR(err),
        .O_CPU_RST_N(cpu_n), .O_BOD_ENABLE(en), .O_BOD_RESET_EN(ren), .O_BOD_HYST(hyst),
        .O_BOD_LEVEL(lvl), .O_REGION_LOCK(lock), .O_CAL_DONE(done));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One classic Wishbone cycle, entered just after a rising edge
    // Waits as long as the slave needs; only the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        chk("bus answer", {31'h0, ack ^ err}, 32'h1);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // Wait for the processor release after a reset
    task automatic run_wait;
        int n;
        n = 0;
        while (cpu_n !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("cpu release", {31'h0, cpu_n}, 32'h1);
        @(posedge clk);
    endtask : run_wait

    // Reset of one kind, then wait for the processor release
    task automatic boot(input logic [1:0] kind, input int len);
        i_fbcl_rst_src.pulse(kind, len);
        run_wait();
    endtask : boot

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // Hang guard, far beyond the expected run
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        int          i;
        logic [5:0]  l;
        logic [31:0] x;
        boot(2'h2, 12);
        // Shipped fuses and their calibration load
        wb(1'b0, 8'h00, 32'h0);
        chk("fuse word", q, 32'he07fffff);
        wb(1'b0, 8'h04, 32'h0);
        chk("ctrl reg", q, 32'h80000007);
        chk("outputs", {22'h0, en, ren, hyst, lvl, done}, 32'h81);
        chk("locks", {16'h0, lock}, 32'h0);
        wb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", {31'h0, e}, 32'h1);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        chk("fuse ro", q, 32'he07fffff);
        $display("test shipped done");
        // Every enable code through a software write
        for (i = 0; i < 4; i++) begin
            l = 6'(i * 13 + 5);
            x = {18'h0, l, 5'h0, i[0], i[1:0]};
            wb(1'b1, 8'h04, x);
            chk("enable", {30'h0, en, ren}, (i == 1) ? 32'h3 : (i == 2) ? 32'h2 : 32'h0);
            chk("hyst", {31'h0, hyst}, {31'h0, i[0]});
            chk("level", {26'h0, lvl}, {26'h0, l});
            wb(1'b0, 8'h04, 32'h0);
            chk("ctrl reg", q, x | 32'h80000000);
        end
        $display("test modes done");
        // Brown-out reset with the flag set keeps the written fields; a write while busy is dropped
        i_fbcl_rst_src.pulse(2'h1, 3);
        wb(1'b0, 8'h08, 32'h0);
        chk("busy", q, 32'h1);
        wb(1'b1, 8'h04, 32'h0);
        run_wait();
        wb(1'b0, 8'h04, 32'h0);
        chk("kept", q, 32'h80002c07);
        wb(1'b0, 8'h08, 32'h0);
        chk("status", q, 32'h2);
        // Plain reset reloads
        boot(2'h0, 3);
        wb(1'b0, 8'h04, 32'h0);
        chk("reload", q, 32'h80000007);
        // Power-on with a brown-out cause: flag clear, so it loads
        wb(1'b1, 8'h04, 32'h00002c07);
        boot(2'h3, 3);
        wb(1'b0, 8'h04, 32'h0);
        chk("por load", q, 32'h80000007);
        $display("test resets done");
        // Chip erase, then a reset loads the erased fields
        erase <= 1'b1;
        repeat (8) @(posedge clk);
        erase <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk("erased", q, 32'h0fffffff);
        boot(2'h0, 3);
        wb(1'b0, 8'h04, 32'h0);
        chk("erased load", q, 32'h80001f00);
        chk("locks", {16'h0, lock}, 32'h0);
        $display("test erase done");
        stop_test();
    end
endmodule : tb
